// ===== verif/adcsq_host_model.sv
// Host serial controller model for the converter sequencer bench.
// Assumes the bench calls xfer from one process at a time.
`default_nettype none
module adcsq_host_model (
  output logic      sclk,
  output logic      cs_n,
  output logic      din,
  input  wire logic dout,
  input  wire logic dout_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam time HALF = 160ns;
  ////////////////////////////////////////////////////////////////////////////
  // The clock stands low outside frames, as a real host would leave it.
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din  = 1'b0;
  end
  // One frame: control byte, then ncyc-8 readback cycles, full duplex.
  // Readback is sampled late in the high phase to leave room for the
  // device's synchroniser delay behind each falling edge.
  task automatic xfer(input logic [7:0] c, input int ncyc,
                      output logic [31:0] rb, output logic [31:0] oem);
    rb  = '0;
    oem = '0;
    cs_n = 1'b0;
    #HALF;
    for (int i = 0; i < ncyc; i++) begin
      din = (i < 8) ? c[7-i] : 1'b0;
      #HALF;
      sclk = 1'b1;
      #(HALF - 20ns);
      if (i >= 8) begin
        // A line the device has let go reads as the inverse of its pin value.
        rb  = {rb[30:0], dout_oe ? dout : ~dout};
        oem = {oem[30:0], dout_oe};
      end
      #20ns;
      sclk = 1'b0;
    end
    #HALF;
    cs_n = 1'b1;
    din  = 1'b0;
    #HALF;
  endtask
endmodule
`default_nettype wire

// ===== verif/tb_adc_serial_mode_sequencer.sv
// Self-checking bench for the converter sequencer: APB master tasks and
// serial frames through the host model. Assumes adcsq_pkg is compiled first.
`default_nettype none
module tb_adc_serial_mode_sequencer import adcsq_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CAL_SIM = 200;
  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, rerr;
  logic        shutdown_pin_n = 1'b1, reset_pin_n = 1'b1;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, rd, rb, oem;
  logic [13:0] sample_code = 14'h0000;
  logic [31:0] prdata;
  logic        pready, pslverr, irq, sclk, cs_n, din, dout, dout_oe;
  logic        strobe, uo0, uo1, uo2, pd;
  int          fails = 0, n_compared = 0, k;

  always #20ns clk_sys = ~clk_sys;

  adcsq_top #(.CAL_CYCLES(CAL_SIM)) dut_u (
    .clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .sclk(sclk), .cs_n(cs_n),
    .din(din), .dout(dout), .dout_oe(dout_oe), .shutdown_pin_n(shutdown_pin_n),
    .reset_pin_n(reset_pin_n), .sample_code(sample_code), .serial_strobe_out(strobe),
    .user_output_0(uo0), .user_output_1(uo1), .user_output_2(uo2), .powered_down(pd));
  adcsq_host_model host_u (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout), .dout_oe(dout_oe));
  ////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("Compared %0d, failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1 && n < 16) begin
      n++;
      @(posedge clk_sys);
    end
    if (n >= 16) begin
      fails++;
      $display("Error at %0t: no bus answer", $time);
      results();
    end
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] mk, input logic [31:0] e, input string m);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd & mk, e, m);
  endtask
  // Pins are compared as {strobe, user 2..0, powered down, irq}.
  task automatic pins(input logic [5:0] e, input string m);
    repeat (4) @(posedge clk_sys);
    chk({26'h0, strobe, uo2, uo1, uo0, pd, irq}, {26'h0, e}, m);
  endtask
  // The code changes after the short sampling point but before the long one.
  task automatic conv(input logic [7:0] c, input int n, input logic [13:0] a, input logic [13:0] b);
    @(posedge clk_sys);
    sample_code <= a;
    fork
      host_u.xfer(c, n, rb, oem);
      begin
        #2600ns;
        @(posedge clk_sys);
        sample_code <= b;
      end
    join
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic clr();
    apb(1'b1, OFS_IRQ_CLEAR, 32'h0000_000F);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (100000) @(posedge clk_sys);
    fails++;
    $display("Error at %0t: run did not finish", $time);
    results();
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (4) @(posedge clk_sys);
    pins(6'b100000, "reset pins");
    rdc(OFS_STATUS, '1, 32'h0000_0040, "reset status");
    apb(1'b0, 8'h14, 32'h0000_0000);
    chk({31'h0, rerr}, 32'h0000_0001, "unmapped error");
    apb(1'b1, OFS_IRQ_ENABLE, 32'h0000_000F);
    rdc(OFS_IRQ_ENABLE, '1, 32'h0000_000F, "irq enable");
    conv(8'h85, 24, 14'h2ABC, 14'h0001);
    chk(rb, 32'h0000_2AF0, "short bipolar bits");
    chk(oem, 32'h0000_FFFF, "short drive");
    pins(6'b110101, "after short");
    rdc(OFS_RESULT, '1, 32'h0000_0ABC, "result");
    rdc(OFS_IRQ_STATUS, '1, 32'h0000_0001, "conv event");
    apb(1'b1, OFS_IRQ_ENABLE, 32'h0000_000E);
    pins(6'b110100, "masked irq");
    clr();
    rdc(OFS_IRQ_STATUS, '1, 32'h0000_0000, "cleared");
    apb(1'b1, OFS_IRQ_ENABLE, 32'h0000_000F);
    conv(8'hF2, 32, 14'h1111, 14'h3456);
    chk(rb, 32'h00FF_D158, "long unipolar bits");
    chk(oem, 32'h0000_FFFF, "long drive");
    rdc(OFS_STATUS, '1, 32'h0000_0020, "long status");
    clr();
    conv(8'hA0, 32, 14'h0F0F, 14'h00FF);
    chk(rb, 32'h00FF_83FC, "powerdown frame");
    pins(6'b100011, "sw down");
    rdc(OFS_STATUS, 32'h0000_00EF, 32'h0000_006B, "down status");
    rdc(OFS_IRQ_STATUS, '1, 32'h0000_0009, "down events");
    clr();
    conv(8'h80, 24, 14'h3FFF, 14'h0000);
    chk(rb, 32'h0000_7FFC, "wake frame");
    pins(6'b100001, "awake");
    clr();
    conv(8'h90, 8, 14'h0000, 14'h0000);
    pins(6'b000000, "cal internal");
    rdc(OFS_STATUS, 32'h0000_0003, 32'h0000_0002, "cal state");
    k = 0;
    while (strobe !== 1'b1 && k < 1000) begin
      k++;
      @(posedge clk_sys);
    end
    chk({31'h0, k > 120 && k <= CAL_SIM}, 32'h0000_0001, "cal length");
    rdc(OFS_IRQ_STATUS, '1, 32'h0000_0002, "cal done");
    clr();
    conv(8'h98, 8, 14'h0000, 14'h0000);
    pins(6'b100000, "cal external");
    rdc(OFS_STATUS, 32'h0000_0083, 32'h0000_0082, "ext cal");
    conv(8'h88, 24, 14'h0000, 14'h0000);
    rdc(OFS_IRQ_STATUS, 32'h0000_0004, 32'h0000_0004, "start abort");
    pins(6'b000001, "ext idle");
    clr();
    conv(8'h98, 8, 14'h0000, 14'h0000);
    shutdown_pin_n <= 1'b0;
    pins(6'b000011, "pin down");
    rdc(OFS_IRQ_STATUS, 32'h0000_0004, 32'h0000_0004, "pin abort");
    shutdown_pin_n <= 1'b1;
    pins(6'b000001, "pin up");
    clr();
    conv(8'h9F, 8, 14'h0000, 14'h0000);
    pins(6'b111100, "cal outs");
    reset_pin_n <= 1'b0;
    repeat (6) @(posedge clk_sys);
    reset_pin_n <= 1'b1;
    pins(6'b100001, "reset pin");
    rdc(OFS_STATUS, '1, 32'h0000_0040, "reset pin status");
    rdc(OFS_IRQ_STATUS, 32'h0000_0004, 32'h0000_0004, "reset abort");
    results();
  end
endmodule
`default_nettype wire

// ===== verilog/adcsq_pkg.sv
// Package for the serial converter mode sequencer: register map, field layout,
// reset values and serial-clock cycle counts.
// Assumes a single system clock domain and an APB master with 32-bit data.
`default_nettype none
package adcsq_pkg;

  // APB register byte offsets.
  localparam logic [7:0]  OFS_STATUS     = 8'h00;
  localparam logic [7:0]  OFS_RESULT     = 8'h04;
  localparam logic [7:0]  OFS_IRQ_STATUS = 8'h08;
  localparam logic [7:0]  OFS_IRQ_CLEAR  = 8'h0C;
  localparam logic [7:0]  OFS_IRQ_ENABLE = 8'h10;

  // Control byte fields, start bit in the most significant position.
  localparam int          CB_POL         = 6;
  localparam int          CB_M1          = 5;
  localparam int          CB_M0          = 4;
  localparam int          CB_EXT         = 3;

  // Event bits of the interrupt registers.
  localparam int          EV_CONV_DONE   = 0;
  localparam int          EV_CAL_DONE    = 1;
  localparam int          EV_CAL_ABORT   = 2;
  localparam int          EV_SHUTDOWN    = 3;
  localparam int          EV_W           = 4;

  // Serial-clock counts, measured from the start bit as cycle 0.
  localparam logic [5:0]  CNT_POL_BIT    = 6'd1;
  localparam logic [5:0]  CNT_CTRL_LAST  = 6'd7;
  localparam logic [5:0]  CNT_SAMPLE_SH  = 6'd6;
  localparam logic [5:0]  CNT_SAMPLE_LG  = 6'd14;
  localparam logic [5:0]  CNT_LOAD_SH    = 6'd7;
  localparam logic [5:0]  CNT_LOAD_LG    = 6'd15;
  localparam logic [5:0]  CNT_PERIOD_SH  = 6'd24;
  localparam logic [5:0]  CNT_PERIOD_LG  = 6'd32;

  // Calibration length in clock cycles.
  localparam int          CAL_CYCLES_DEF = 80000;

  // Reset values: synchroniser bits are reset_n, shutdown_n, din, cs_n, sclk.
  localparam logic [4:0]  SYNC_RST       = 5'b11010;
  localparam logic [EV_W-1:0] IRQ_EN_RST = 4'h0;

  typedef enum logic [1:0] {
    ADCSQ_IDLE  = 2'b00,
    ADCSQ_FRAME = 2'b01,
    ADCSQ_CAL   = 2'b10,
    ADCSQ_SHUTDOWN_PIN_N  = 2'b11
  } adcsq_state_t;

endpackage
`default_nettype wire

// ===== verilog/adcsq_top.sv
// Mode and sequencing logic of a serially controlled 14-bit converter,
// with an APB register port and a level interrupt.
// Assumes serial pins and reset pin are asynchronous to clk_sys and that the
// analog core presents an offset-binary code on sample_code in the clk_sys domain.
`default_nettype none
module adcsq_top
  import adcsq_pkg::*;
#(
  parameter int CAL_CYCLES = CAL_CYCLES_DEF
) (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  output var  logic        irq,
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        din,
  output var  logic        dout,
  output var  logic        dout_oe,
  input  wire logic        shutdown_pin_n,
  input  wire logic        reset_pin_n,
  input  wire logic [13:0] sample_code,
  output var  logic        serial_strobe_out,
  output var  logic        user_output_0,
  output var  logic        user_output_1,
  output var  logic        user_output_2,
  output var  logic        powered_down
);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [4:0]      s1;
    logic [4:0]      s2;
    logic [4:0]      s3;
    adcsq_state_t    state;
    logic [5:0]      bitcnt;
    logic [7:0]      rx;
    logic [15:0]     tx;
    logic            long_acq;
    logic            bipolar;
    logic            ext_clk;
    logic            pd_pending;
    logic            sw_down;
    logic [2:0]      user_out;
    logic            strobe;
    logic            pwr_dn;
    logic            dout;
    logic            dout_oe;
    logic [16:0]     cal_cnt;
    logic [13:0]     result;
    logic [EV_W-1:0] irq_st;
    logic [EV_W-1:0] irq_en;
    logic            irq;
    logic            pready;
    logic            pslverr;
    logic [31:0]     prdata;
  } adcsq_regs_t;

  localparam logic [16:0] CAL_LAST = 17'(CAL_CYCLES - 1);

  adcsq_regs_t st;
  adcsq_regs_t next_st;

  default clocking adcsq_cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  // Decoded views of the second synchroniser stage and edge strobes.
  logic        sclk_rise;
  logic        sclk_fall;
  logic        cs_low;
  logic        din_s;
  logic        shutdown_pin_n_low;
  logic        rstpin_low;
  logic        start_bit;
  logic [13:0] coded;
  logic        apb_access;
  logic        apb_wr;

  assign sclk_rise  = st.s2[0] & ~st.s3[0];
  assign sclk_fall  = ~st.s2[0] & st.s3[0];
  assign cs_low     = ~st.s2[1];
  assign din_s      = st.s2[2];
  assign shutdown_pin_n_low   = ~st.s2[3];
  assign rstpin_low = ~st.s2[4];
  assign start_bit  = sclk_rise & cs_low & din_s & (st.state != ADCSQ_FRAME);
  // The core delivers offset binary; flipping the MSB gives two's complement.
  assign coded      = st.bipolar ? {~sample_code[13], sample_code[12:0]} : sample_code;
  assign apb_access = psel & penable & ~st.pready;
  assign apb_wr     = psel & penable & st.pready & pwrite;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [7:0]      cbyte;
    logic [EV_W-1:0] ev;
    logic [5:0]      sample_at;
    logic [5:0]      load_at;
    logic [5:0]      period;
    cbyte     = {st.rx[6:0], din_s};
    ev        = '0;
    sample_at = st.long_acq ? CNT_SAMPLE_LG : CNT_SAMPLE_SH;
    load_at   = st.long_acq ? CNT_LOAD_LG : CNT_LOAD_SH;
    period    = st.long_acq ? CNT_PERIOD_LG : CNT_PERIOD_SH;
    next_st   = st;
    next_st.s1 = {reset_pin_n, shutdown_pin_n, din, cs_n, sclk};
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;

    unique case (st.state)
      ADCSQ_IDLE: begin
        if (start_bit) begin
          next_st.state  = ADCSQ_FRAME;
          next_st.bitcnt = '0;
          next_st.rx     = 8'h01;
        end
      end
      ADCSQ_FRAME: begin
        if (!cs_low) begin
          next_st.state   = ADCSQ_IDLE;
          next_st.dout_oe = 1'b0;
          next_st.dout    = 1'b0;
        end else if (sclk_rise) begin
          next_st.bitcnt = st.bitcnt + 6'd1;
          next_st.rx     = cbyte;
          if (st.bitcnt + 6'd1 == CNT_POL_BIT) begin
            next_st.bipolar = ~din_s;
          end
          if (st.bitcnt + 6'd1 == CNT_CTRL_LAST) begin
            next_st.user_out = cbyte[2:0];
            next_st.ext_clk  = cbyte[CB_EXT];
            unique case ({cbyte[CB_M1], cbyte[CB_M0]})
              2'b00: next_st.long_acq = 1'b0;
              2'b11: next_st.long_acq = 1'b1;
              2'b10: next_st.pd_pending = 1'b1;
              2'b01: begin
                next_st.state   = ADCSQ_CAL;
                next_st.cal_cnt = '0;
                next_st.dout_oe = 1'b0;
              end
            endcase
          end
        end else if (sclk_fall) begin
          // Short mode latches at the falling edge of cycle 6; long mode overwrites at its own instant.
          if (st.bitcnt == CNT_SAMPLE_SH || st.bitcnt == sample_at) begin
            next_st.result = coded;
          end
          if (st.bitcnt == load_at) begin
            next_st.dout    = st.result[13];
            next_st.tx      = {st.result[12:0], 3'b000};
            next_st.dout_oe = 1'b1;
          end else if (st.bitcnt > load_at) begin
            next_st.dout = st.tx[15];
            next_st.tx   = {st.tx[14:0], 1'b0};
          end
          if (st.bitcnt == period - 6'd1) begin
            ev[EV_CONV_DONE] = 1'b1;
            next_st.dout_oe  = 1'b0;
            next_st.dout     = 1'b0;
            if (st.pd_pending) begin
              next_st.state      = ADCSQ_SHUTDOWN_PIN_N;
              next_st.sw_down    = 1'b1;
              next_st.pd_pending = 1'b0;
              ev[EV_SHUTDOWN]    = 1'b1;
            end else begin
              next_st.state = ADCSQ_IDLE;
            end
          end
        end
      end
      ADCSQ_CAL: begin
        next_st.cal_cnt = st.cal_cnt + 17'd1;
        if (start_bit) begin
          next_st.state    = ADCSQ_FRAME;
          next_st.bitcnt   = '0;
          next_st.rx       = 8'h01;
          ev[EV_CAL_ABORT] = 1'b1;
        end else if (st.cal_cnt == CAL_LAST) begin
          next_st.state   = ADCSQ_IDLE;
          ev[EV_CAL_DONE] = 1'b1;
        end
      end
      ADCSQ_SHUTDOWN_PIN_N: begin
        if (!shutdown_pin_n_low && !st.sw_down) begin
          next_st.state = ADCSQ_IDLE;
        end else if (!shutdown_pin_n_low && start_bit) begin
          next_st.state   = ADCSQ_FRAME;
          next_st.sw_down = 1'b0;
          next_st.bitcnt  = '0;
          next_st.rx      = 8'h01;
        end
      end
    endcase

    // The shutdown pin overrides any activity, including a calibration.
    if (shutdown_pin_n_low && st.state != ADCSQ_SHUTDOWN_PIN_N) begin
      next_st.state   = ADCSQ_SHUTDOWN_PIN_N;
      next_st.dout_oe = 1'b0;
      ev[EV_SHUTDOWN] = 1'b1;
      if (st.state == ADCSQ_CAL) begin
        ev[EV_CAL_ABORT] = 1'b1;
      end
    end

    if (rstpin_low) begin
      next_st.state      = ADCSQ_IDLE;
      next_st.user_out   = 3'b000;
      next_st.bipolar    = 1'b1;
      next_st.ext_clk    = 1'b0;
      next_st.long_acq   = 1'b0;
      next_st.pd_pending = 1'b0;
      next_st.sw_down    = 1'b0;
      next_st.dout_oe    = 1'b0;
      next_st.dout       = 1'b0;
      if (st.state == ADCSQ_CAL) begin
        ev[EV_CAL_ABORT] = 1'b1;
      end
    end

    // Internal clocking strobes low during calibration; external strobes high.
    next_st.strobe = next_st.ext_clk ? (next_st.state == ADCSQ_CAL) : (next_st.state != ADCSQ_CAL);
    next_st.pwr_dn = (next_st.state == ADCSQ_SHUTDOWN_PIN_N);

    // A write is applied at the edge where pready is sampled high.
    next_st.pready  = apb_access;
    next_st.pslverr = 1'b0;
    if (apb_access) begin
      next_st.prdata = '0;
      unique case (paddr)
        OFS_STATUS:     next_st.prdata = {24'h0000_00, st.ext_clk, st.bipolar, st.long_acq,
                                          st.pd_pending, st.sw_down, 1'b0, st.state};
        OFS_RESULT:     next_st.prdata = {18'h0_0000, st.result};
        OFS_IRQ_STATUS: next_st.prdata = {28'h000_0000, st.irq_st};
        OFS_IRQ_ENABLE: next_st.prdata = {28'h000_0000, st.irq_en};
        OFS_IRQ_CLEAR:  next_st.prdata = '0;
        default:        next_st.pslverr = 1'b1;
      endcase
    end
    if (apb_wr && paddr == OFS_IRQ_CLEAR) begin
      next_st.irq_st = st.irq_st & ~pwdata[EV_W-1:0];
    end
    if (apb_wr && paddr == OFS_IRQ_ENABLE) begin
      next_st.irq_en = pwdata[EV_W-1:0];
    end
    // Setting after clearing lets a same-cycle event survive the clear.
    next_st.irq_st = next_st.irq_st | ev;
    next_st.irq    = |(next_st.irq_st & next_st.irq_en);
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st          <= '0;
      st.s1       <= SYNC_RST;
      st.s2       <= SYNC_RST;
      st.s3       <= SYNC_RST;
      st.bipolar  <= 1'b1;
      st.strobe   <= 1'b1;
      st.irq_en   <= IRQ_EN_RST;
    end else begin
      st <= next_st;
    end
  end

  assign prdata            = st.prdata;
  assign pready            = st.pready;
  assign pslverr           = st.pslverr;
  assign irq               = st.irq;
  assign dout              = st.dout;
  assign dout_oe           = st.dout_oe;
  assign serial_strobe_out = st.strobe;
  assign user_output_0     = st.user_out[0];
  assign user_output_1     = st.user_out[1];
  assign user_output_2     = st.user_out[2];
  assign powered_down      = st.pwr_dn;

  ////////////////////////////////////////////////////////////////////////////
  sequence s_start;
    start_bit && !shutdown_pin_n_low && !rstpin_low;
  endsequence

  sequence s_cal_end;
    st.state == ADCSQ_CAL && st.cal_cnt == CAL_LAST && !start_bit && !shutdown_pin_n_low && !rstpin_low;
  endsequence

  property p_cal_len;
    s_cal_end |=> st.state == ADCSQ_IDLE && st.irq_st[EV_CAL_DONE];
  endproperty
  a_cal_len: assert property (p_cal_len) else $error("calibration did not end at its count");
  property p_cal_abort;
    ((st.state == ADCSQ_CAL) and s_start) |=> st.state == ADCSQ_FRAME && st.irq_st[EV_CAL_ABORT];
  endproperty
  a_cal_abort: assert property (p_cal_abort) else $error("start bit did not abort calibration");
  property p_shutdown_pin_n_pin;
    shutdown_pin_n_low && !rstpin_low |=> st.state == ADCSQ_SHUTDOWN_PIN_N;
  endproperty
  a_shutdown_pin_n_pin: assert property (p_shutdown_pin_n_pin) else $error("shutdown pin ignored");
  property p_rst_pin;
    rstpin_low |=> st.user_out == 3'b000 && st.bipolar && !st.ext_clk && st.state == ADCSQ_IDLE;
  endproperty
  a_rst_pin: assert property (p_rst_pin) else $error("reset pin defaults not applied");
  property p_strobe;
    $rose(st.state == ADCSQ_CAL) |-> (serial_strobe_out == st.ext_clk) ##1 (serial_strobe_out == st.ext_clk);
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe wrong during calibration");
  property p_pol;
    st.state == ADCSQ_FRAME && cs_low && sclk_rise && st.bitcnt == 6'd0 && !rstpin_low && !shutdown_pin_n_low
      |=> st.bipolar == !$past(din_s);
  endproperty
  a_pol: assert property (p_pol) else $error("polarity bit not applied at once");
  property p_sample;
    st.state == ADCSQ_FRAME && cs_low && sclk_fall && st.bitcnt == CNT_SAMPLE_SH && !rstpin_low
      |=> st.result == $past(coded);
  endproperty
  a_sample: assert property (p_sample) else $error("short sample not taken");
  property p_short_end;
    st.state == ADCSQ_FRAME && cs_low && sclk_fall && !st.long_acq && st.bitcnt == 6'd23
      |=> st.state != ADCSQ_FRAME && st.irq_st[EV_CONV_DONE];
  endproperty
  a_short_end: assert property (p_short_end) else $error("short period not 24 cycles");
  property p_long_end;
    st.state == ADCSQ_FRAME && cs_low && sclk_fall && st.long_acq && st.bitcnt == 6'd31
      |=> st.state != ADCSQ_FRAME;
  endproperty
  a_long_end: assert property (p_long_end) else $error("long period not 32 cycles");
  property p_sw_pd;
    st.state == ADCSQ_FRAME && cs_low && sclk_fall && st.pd_pending && !shutdown_pin_n_low && !rstpin_low
      && st.bitcnt == (st.long_acq ? 6'd31 : 6'd23) |=> st.state == ADCSQ_SHUTDOWN_PIN_N ##1 st.sw_down;
  endproperty
  a_sw_pd: assert property (p_sw_pd) else $error("software power-down not entered");
  property p_wake;
    ((st.state == ADCSQ_SHUTDOWN_PIN_N && st.sw_down) and s_start) |=> st.state == ADCSQ_FRAME;
  endproperty
  a_wake: assert property (p_wake) else $error("start bit did not wake device");
  property p_irq;
    ##1 irq == |($past(next_st.irq_st) & $past(next_st.irq_en));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt level mismatch");

endmodule
`default_nettype wire
